// ==== dv/asid_core.sv ====
// core sequencer model: issues words, holds accumulator and register b
`timescale 1ns/1ps
module asid_core (
  input wire logic clk_sys,
  output logic instr_valid,
  output logic [9:0] instr_word,
  output logic [3:0] acc_in,
  output logic [3:0] regb_in,
  input wire logic [3:0] acc_out,
  input wire logic acc_we,
  input wire logic [3:0] regb_out,
  input wire logic regb_we,
  input wire logic skip_next
);
  int n_skip = 0;
  initial
  begin
    instr_valid = 1'b0;
    instr_word = 10'h3ff;
    acc_in = 4'h0;
    regb_in = 4'h0;
  end
  // skipping is counted, not acted on: the bench picks every later word itself
  always @(posedge clk_sys)
  begin
    if (acc_we) acc_in <= acc_out;
    if (regb_we) regb_in <= regb_out;
    if (skip_next) n_skip <= n_skip + 1;
  end
  // only assigned codes are handed in; idle word is inverted so it never reads stale
  task iss(input logic [9:0] w0, input logic [9:0] w1, input int n);
    instr_valid <= 1'b1;
    instr_word <= w0;
    @(posedge clk_sys);
    if (n > 1)
    begin
      instr_word <= w1;
      @(posedge clk_sys);
    end
    instr_valid <= 1'b0;
    instr_word <= ~w1;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the converter and system instruction decoder
`timescale 1ns/1ps
`include "asid_cfg.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module tb;
  import asid_pkg::*;
  logic clk_sys = 0;
  logic sys_rst = 1;
  logic instr_valid, acc_we, regb_we, skip_next, conv_start, cmp_start, ram_backup;
  logic wdt_stop, sys_reset_req, operand_valid, conv_done_flag, irq;
  logic [9:0] instr_word;
  logic [3:0] acc_in, regb_in, acc_out, regb_out;
  logic [7:0] cmp_ref;
  logic [9:0] adc_result = 10'h2d6;
  logic conv_complete = 0, converter_irq_enable_bit = 0, power_flag_in = 0;
  logic watchdog_flag_one_set = 0, port_bit_in = 1;
  asid_operand_t operand;
  asid_axi_m2s_t m = '0;
  asid_axi_s2m_t s;
  int mismatches = 0, compares = 0, n_cv = 0, n_cm = 0, n_bk = 0, n_op = 0, n_sr = 0, nsk;
  logic [31:0] rd;
  logic [1:0] rr;
  assign nsk = asid_core_i.n_skip;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    n_cv <= n_cv + conv_start;
    n_cm <= n_cm + cmp_start;
    n_bk <= n_bk + ram_backup;
    n_op <= n_op + operand_valid;
    n_sr <= n_sr + sys_reset_req;
  end
  asid_decode asid_decode_i (.clk_sys, .sys_rst, .instr_valid, .instr_word, .acc_in,
    .regb_in, .adc_result, .conv_complete, .converter_irq_enable_bit, .power_flag_in,
    .watchdog_flag_one_set, .port_bit_in, .acc_out, .acc_we, .regb_out, .regb_we,
    .skip_next,
    .conv_start, .cmp_start, .cmp_ref, .ram_backup, .wdt_stop, .sys_reset_req,
    .operand_valid, .operand, .conv_done_flag, .irq, .axi_m2s(m), .axi_s2m(s));
  asid_core asid_core_i (.clk_sys, .instr_valid, .instr_word, .acc_in, .regb_in,
    .acc_out, .acc_we, .regb_out, .regb_we, .skip_next);
  task give_verdict;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task iss(input logic [9:0] w0, input logic [9:0] w1 = 10'h0, input int n = 1);
    asid_core_i.iss(w0, w1, n);
  endtask
  task setab(input logic [3:0] a, input logic [3:0] b);
    asid_core_i.acc_in <= a;
    asid_core_i.regb_in <= b;
    @(posedge clk_sys);
  endtask
  task ev(input bit wd);
    if (wd) watchdog_flag_one_set <= 1'b1;
    else conv_complete <= 1'b1;
    @(posedge clk_sys);
    watchdog_flag_one_set <= 1'b0;
    conv_complete <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task axw(input logic [31:0] ad, input logic [31:0] d);
    int k;
    m <= {1'b1, ad, 1'b1, d, 4'hf, 1'b1, 1'b0, 32'h0, 1'b0};
    for (k = 0; k < 40; k++)
    begin
      @(posedge clk_sys);
      if (s.awready) m.awvalid <= 1'b0;
      if (s.wready) m.wvalid <= 1'b0;
      if (s.bvalid) break;
    end
    m.bready <= 1'b0;
    rr = s.bresp;
    if (k == 40)
    begin
      mismatches++;
      give_verdict();
    end
    // one edge between transfers so the next request never reassigns in this step
    @(posedge clk_sys);
  endtask
  task axr(input logic [31:0] ad);
    int k;
    m <= {1'b0, 32'h0, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, ad, 1'b1};
    for (k = 0; k < 40; k++)
    begin
      @(posedge clk_sys);
      if (s.arready) m.arvalid <= 1'b0;
      if (s.rvalid) break;
    end
    m.rready <= 1'b0;
    rd = s.rdata;
    rr = s.rresp;
    if (k == 40)
    begin
      mismatches++;
      give_verdict();
    end
    @(posedge clk_sys);
  endtask
  task t_pair;
    iss(`ASID_OP_READ_RESULT_PAIR);
    `CHK(regb_in, 4'hb)
    `CHK(acc_in, 4'h5)
    iss(`ASID_OP_READ_RESULT_LOW_BITS);
    `CHK(acc_in, 4'h8)
  endtask
  task t_start(input int md);
    int cv, cm;
    ev(0);
    `CHK(conv_done_flag, 1'b1)
    cv = n_cv;
    cm = n_cm;
    iss(`ASID_OP_START_CONVERSION);
    `CHK(conv_done_flag, 1'b0)
    `CHK(n_cv, cv + 1 - md)
    `CHK(n_cm, cm + md)
  endtask
  // ctrl1 ends at 4'h8, so comparator mode holds from here on
  task t_ctrl;
    for (int i = 0; i < 3; i++)
    begin
      setab(4'h8 + 4'(i), 4'h0);
      iss(`ASID_OP_WR_CTRL1 + 10'(i));
      setab(4'h0, 4'h0);
      iss(`ASID_OP_RD_CTRL1 + 10'(i));
      `CHK(acc_in, 4'h8 + 4'(i))
    end
  endtask
  task t_cmp;
    iss(`ASID_OP_READ_RESULT_PAIR);
    `CHK(regb_in, 4'hd)
    `CHK(acc_in, 4'h6)
    setab(4'h3, 4'ha);
    iss(`ASID_OP_LOAD_COMPARATOR_REF);
    `CHK(cmp_ref, 8'ha3)
  endtask
  task t_done;
    int sk;
    ev(0);
    sk = nsk;
    converter_irq_enable_bit <= 1'b1;
    iss(`ASID_OP_TEST_CONV_DONE);
    `CHK(nsk, sk)
    `CHK(conv_done_flag, 1'b1)
    converter_irq_enable_bit <= 1'b0;
    iss(`ASID_OP_TEST_CONV_DONE);
    `CHK(nsk, sk + 1)
    `CHK(conv_done_flag, 1'b0)
  endtask
  task t_pow;
    int sk;
    sk = nsk;
    iss(`ASID_OP_POWER_OFF);
    `CHK(n_bk, 0)
    iss(`ASID_OP_POWER_OFF_ENABLE, `ASID_OP_NO_OPERATION, 2);
    `CHK(nsk, sk)
    `CHK(acc_in, 4'h3)
    iss(`ASID_OP_POWER_OFF);
    `CHK(n_bk, 0)
    iss(`ASID_OP_POWER_OFF_ENABLE, `ASID_OP_POWER_OFF, 2);
    `CHK(n_bk, 1)
    power_flag_in <= 1'b1;
    iss(`ASID_OP_TEST_POWER_DOWN_FLAG);
    `CHK(nsk, sk + 1)
  endtask
  task t_wd;
    int sk;
    sk = nsk;
    ev(1);
    iss(`ASID_OP_WATCHDOG_RESTART);
    `CHK(nsk, sk + 1)
    iss(`ASID_OP_WATCHDOG_RESTART);
    `CHK(nsk, sk + 1)
    `CHK(wdt_stop, 1'b0)
    iss(`ASID_OP_WATCHDOG_DISABLE, `ASID_OP_WATCHDOG_RESTART, 2);
    `CHK(wdt_stop, 1'b1)
    iss(`ASID_OP_SOFTWARE_RESET);
    `CHK(n_sr, 1)
  endtask
  task t_two;
    int sk;
    sk = nsk;
    iss(`ASID_OP_EQUAL_IMMEDIATE_TEST, {`ASID_W2_EQ_HI, 4'h3}, 2);
    `CHK(nsk, sk + 1)
    `CHK(n_op, 1)
    iss(10'h0e0, 10'h2d5, 2);
    `CHK(operand.page, 7'h01)
    `CHK(operand.addr, 7'h55)
    `CHK(operand.call, 1'b0)
    `CHK(operand.kind, ASID_W2_LONG)
    iss(10'h0c0, 10'h2d5, 2);
    `CHK(operand.call, 1'b1)
    `CHK(operand.page, 7'h01)
    iss(`ASID_OP_INDEXED_LONG_JUMP, 10'h2c5, 2);
    `CHK(operand.page, 7'h35)
    `CHK(operand.addr, 7'h00)
    `CHK(operand.kind, ASID_W2_INDEX)
    port_bit_in <= 1'b0;
    iss(`ASID_OP_PORT_BIT_ZERO_TEST, `ASID_W2_PORT_WORD, 2);
    `CHK(nsk, sk + 2)
  endtask
  task t_irq;
    axw(32'h0, 32'hf);
    `CHK(rr, `ASID_RESP_OKAY)
    `CHK(irq, 1'b0)
    ev(0);
    `CHK(irq, 1'b0)
    axw(32'h4, 32'h1);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    axr(32'h0);
    `CHK(rd, 32'h1)
    axr(32'h18);
    `CHK(rd, 32'hd)
    axw(32'h0, 32'h1);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    axr(32'h1c);
    `CHK(rr, `ASID_RESP_SLVERR)
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_pair();
    t_start(0);
    t_ctrl();
    t_cmp();
    t_start(1);
    t_done();
    t_pow();
    t_wd();
    t_two();
    t_irq();
    give_verdict();
  end
endmodule

// ==== logic/asid_cfg.svh ====
// offsets, opcodes, field positions and reset values for the converter/system decoder
`ifndef ASID_CFG_SVH
`define ASID_CFG_SVH

// instruction word framing
`define ASID_WORD_W 10
`define ASID_HI_MSB 9
`define ASID_HI_LSB 4
`define ASID_LO_MSB 3
`define ASID_LO_LSB 0

// one-word opcodes
`define ASID_OP_READ_RESULT_PAIR 10'h279
`define ASID_OP_READ_RESULT_LOW_BITS 10'h249
`define ASID_OP_LOAD_COMPARATOR_REF 10'h239
`define ASID_OP_START_CONVERSION 10'h29f
`define ASID_OP_TEST_CONV_DONE 10'h287
`define ASID_OP_RD_CTRL1 10'h244
`define ASID_OP_WR_CTRL1 10'h204
`define ASID_OP_RD_CTRL2 10'h245
`define ASID_OP_WR_CTRL2 10'h205
`define ASID_OP_RD_CTRL3 10'h246
`define ASID_OP_WR_CTRL3 10'h206
`define ASID_OP_NO_OPERATION 10'h000
`define ASID_OP_SOFTWARE_RESET 10'h001
`define ASID_OP_POWER_OFF 10'h002
`define ASID_OP_TEST_POWER_DOWN_FLAG 10'h003
`define ASID_OP_POWER_OFF_ENABLE 10'h05b
`define ASID_OP_WATCHDOG_RESTART 10'h2a0
`define ASID_OP_WATCHDOG_DISABLE 10'h29c

// two-word first words
`define ASID_OP_INDEXED_LONG_JUMP 10'h010
`define ASID_OP_INDEXED_LONG_CALL 10'h030
`define ASID_OP_PORT_BIT_ZERO_TEST 10'h024
`define ASID_OP_EQUAL_IMMEDIATE_TEST 10'h025
`define ASID_HI5_LONG_JUMP 5'h07
`define ASID_HI5_LONG_CALL 5'h06

// second-word fixed fields
`define ASID_W2_EQ_HI 6'h07
`define ASID_W2_PORT_WORD 10'h02b

// control register fields
`define ASID_MODE_BIT 3
`define ASID_CTRL_RESET 4'h0
`define ASID_REF_RESET 8'h00

// bus register map as word indices; the byte address is four times the index
`define ASID_OFF_STATUS 3'h0
`define ASID_OFF_MASK 3'h1
`define ASID_OFF_CTRL1 3'h2
`define ASID_OFF_CTRL2 3'h3
`define ASID_OFF_CTRL3 3'h4
`define ASID_OFF_CMPREF 3'h5
`define ASID_OFF_STATE 3'h6
`define ASID_OFF_LAST 3'h6

// status bit positions
`define ASID_ST_W 4
`define ASID_ST_DONE 0
`define ASID_ST_WDF 1
`define ASID_ST_BACKUP 2
`define ASID_ST_SWRST 3

`define ASID_RESP_OKAY 2'b00
`define ASID_RESP_SLVERR 2'b10

`endif

// ==== logic/asid_decode.sv ====
// converter and system-control instruction decoder with axi4-lite register slave
`timescale 1ns/1ps
`include "asid_cfg.svh"

module asid_decode (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [9:0] instr_word,
  input wire logic [3:0] acc_in,
  input wire logic [3:0] regb_in,
  input wire logic [9:0] adc_result,
  input wire logic conv_complete,
  input wire logic converter_irq_enable_bit,
  input wire logic power_flag_in,
  input wire logic watchdog_flag_one_set,
  input wire logic port_bit_in,
  output logic [3:0] acc_out,
  output logic acc_we,
  output logic [3:0] regb_out,
  output logic regb_we,
  output logic skip_next,
  output logic conv_start,
  output logic cmp_start,
  output logic [7:0] cmp_ref,
  output logic ram_backup,
  output logic wdt_stop,
  output logic sys_reset_req,
  output logic operand_valid,
  output asid_pkg::asid_operand_t operand,
  output logic conv_done_flag,
  output logic irq,
  input wire asid_pkg::asid_axi_m2s_t axi_m2s,
  output asid_pkg::asid_axi_s2m_t axi_s2m
);
  import asid_pkg::*;

  // decode a bus byte address into {hit, register index}; reused by both channels
  function automatic logic [3:0] reg_sel(input logic [31:0] a);
    logic [2:0] idx;
    idx = a[4:2];
    if (a[31:5] == 27'h0 && a[1:0] == 2'b00 && idx <= `ASID_OFF_LAST)
      reg_sel = {1'b1, idx};
    else
      reg_sel = 4'h0;
  endfunction

  // write opcodes of the three control registers
  function automatic logic [9:0] ctrl_wr_op(input int i);
    case (i)
      0: ctrl_wr_op = `ASID_OP_WR_CTRL1;
      1: ctrl_wr_op = `ASID_OP_WR_CTRL2;
      default: ctrl_wr_op = `ASID_OP_WR_CTRL3;
    endcase
  endfunction

  logic [5:0] hi_f;
  logic [3:0] lo_f;
  logic [9:0] op;
  logic first_ok;
  logic second_ok;
  asid_state_t state_r;
  asid_state_t state_nxt;
  asid_w2_t pend_kind_r;
  logic pend_call_r;
  logic [3:0] ctrl_r [3];
  logic mode;
  logic conv_done_flag_r;
  logic watchdog_flag_one_r;
  logic pwr_off_armed_r;
  logic wd_disable_armed_r;
  logic two_word;
  asid_w2_t w2_kind;
  logic w2_call;

  assign hi_f = instr_word[`ASID_HI_MSB:`ASID_HI_LSB];
  assign lo_f = instr_word[`ASID_LO_MSB:`ASID_LO_LSB];
  assign op = {hi_f, lo_f};
  assign first_ok = instr_valid && state_r == ASID_ST_FIRST;
  assign second_ok = instr_valid && state_r == ASID_ST_SECOND;
  assign mode = ctrl_r[0][`ASID_MODE_BIT];

  // first-word classification of two-word forms
  always_comb
  begin
    two_word = 1'b1;
    w2_kind = ASID_W2_LONG;
    w2_call = 1'b0;
    if (hi_f[5:1] == `ASID_HI5_LONG_JUMP)
    begin
      w2_kind = ASID_W2_LONG;
    end
    else if (hi_f[5:1] == `ASID_HI5_LONG_CALL)
    begin
      w2_call = 1'b1;
    end
    else if (op == `ASID_OP_INDEXED_LONG_JUMP)
    begin
      w2_kind = ASID_W2_INDEX;
    end
    else if (op == `ASID_OP_INDEXED_LONG_CALL)
    begin
      w2_kind = ASID_W2_INDEX;
      w2_call = 1'b1;
    end
    else if (op == `ASID_OP_EQUAL_IMMEDIATE_TEST)
    begin
      w2_kind = ASID_W2_EQ;
    end
    else if (op == `ASID_OP_PORT_BIT_ZERO_TEST)
    begin
      w2_kind = ASID_W2_PORT;
    end
    else
    begin
      two_word = 1'b0;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ASID_ST_FIRST: if (first_ok && two_word) state_nxt = ASID_ST_SECOND;
      ASID_ST_SECOND: if (second_ok) state_nxt = ASID_ST_FIRST;
      default: state_nxt = ASID_ST_FIRST;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= ASID_ST_FIRST;
      pend_kind_r <= ASID_W2_LONG;
      pend_call_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (first_ok && two_word)
      begin
        pend_kind_r <= w2_kind;
        pend_call_r <= w2_call;
      end
    end
  end

  // operand of a two-word instruction; page bits not taken from the second word are zero
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      operand_valid <= 1'b0;
      operand <= '0;
    end
    else
    begin
      operand_valid <= second_ok;
      if (second_ok)
      begin
        operand.call <= pend_call_r;
        operand.kind <= pend_kind_r;
        case (pend_kind_r)
          ASID_W2_LONG:
          begin
            operand.page <= {5'h00, instr_word[8:7]};
            operand.addr <= instr_word[6:0];
          end
          ASID_W2_INDEX:
          begin
            operand.page <= {instr_word[8:6], instr_word[3:0]};
            operand.addr <= 7'h00;
          end
          default:
          begin
            operand.page <= 7'h00;
            operand.addr <= {3'h0, lo_f};
          end
        endcase
      end
    end
  end

  // accumulator and B write-back toward the core
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc_out <= 4'h0;
      acc_we <= 1'b0;
      regb_out <= 4'h0;
      regb_we <= 1'b0;
    end
    else
    begin
      acc_we <= 1'b0;
      regb_we <= 1'b0;
      if (first_ok)
      begin
        case (op)
          `ASID_OP_READ_RESULT_PAIR:
          begin
            acc_we <= 1'b1;
            regb_we <= 1'b1;
            if (mode)
            begin
              regb_out <= adc_result[7:4];
              acc_out <= adc_result[3:0];
            end
            else
            begin
              regb_out <= adc_result[9:6];
              acc_out <= adc_result[5:2];
            end
          end
          `ASID_OP_READ_RESULT_LOW_BITS:
          begin
            acc_we <= 1'b1;
            acc_out <= {adc_result[1:0], 2'b00};
          end
          `ASID_OP_RD_CTRL1:
          begin
            acc_we <= 1'b1;
            acc_out <= ctrl_r[0];
          end
          `ASID_OP_RD_CTRL2:
          begin
            acc_we <= 1'b1;
            acc_out <= ctrl_r[1];
          end
          `ASID_OP_RD_CTRL3:
          begin
            acc_we <= 1'b1;
            acc_out <= ctrl_r[2];
          end
          default:
          begin
            acc_we <= 1'b0;
          end
        endcase
      end
    end
  end

  // bus write path
  logic aw_rdy_r;
  logic w_rdy_r;
  logic b_vld_r;
  logic [1:0] b_resp_r;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic w_lane_q;
  logic wr_fire;
  logic [3:0] wsel;
  logic [`ASID_ST_W-1:0] status_r;
  logic [`ASID_ST_W-1:0] mask_r;
  logic [`ASID_ST_W-1:0] ev;
  logic [`ASID_ST_W-1:0] w1c;

  assign wr_fire = !aw_rdy_r && !w_rdy_r && !b_vld_r;
  assign wsel = reg_sel(aw_addr_q);

  // control registers; an instruction write beats a bus write in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 3; i++)
        ctrl_r[i] <= `ASID_CTRL_RESET;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (first_ok && op == ctrl_wr_op(i))
          ctrl_r[i] <= acc_in;
        else if (wr_fire && w_lane_q && wsel == {1'b1, 3'(`ASID_OFF_CTRL1 + i)})
          ctrl_r[i] <= w_data_q[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cmp_ref <= `ASID_REF_RESET;
    else if (first_ok && op == `ASID_OP_LOAD_COMPARATOR_REF && mode)
      cmp_ref <= {regb_in, acc_in};
    else if (wr_fire && w_lane_q && wsel == {1'b1, `ASID_OFF_CMPREF})
      cmp_ref <= w_data_q[7:0];
  end

  // converter start and done flag; a completing conversion wins over any clear
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      conv_done_flag_r <= 1'b0;
      conv_start <= 1'b0;
      cmp_start <= 1'b0;
    end
    else
    begin
      conv_start <= first_ok && op == `ASID_OP_START_CONVERSION && !mode;
      cmp_start <= first_ok && op == `ASID_OP_START_CONVERSION && mode;
      if (conv_complete)
        conv_done_flag_r <= 1'b1;
      else if (first_ok && op == `ASID_OP_START_CONVERSION)
        conv_done_flag_r <= 1'b0;
      else if (first_ok && op == `ASID_OP_TEST_CONV_DONE && !converter_irq_enable_bit)
        conv_done_flag_r <= 1'b0;
    end
  end
  assign conv_done_flag = conv_done_flag_r;

  // skip decision for every skipping form
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      skip_next <= 1'b0;
    else if (first_ok)
    begin
      case (op)
        `ASID_OP_TEST_CONV_DONE: skip_next <= !converter_irq_enable_bit && conv_done_flag_r;
        `ASID_OP_TEST_POWER_DOWN_FLAG: skip_next <= power_flag_in;
        `ASID_OP_WATCHDOG_RESTART: skip_next <= watchdog_flag_one_r;
        default: skip_next <= 1'b0;
      endcase
    end
    else if (second_ok && pend_kind_r == ASID_W2_EQ)
      skip_next <= instr_word[9:4] == `ASID_W2_EQ_HI && acc_in == lo_f;
    else if (second_ok && pend_kind_r == ASID_W2_PORT)
      skip_next <= instr_word == `ASID_W2_PORT_WORD && !port_bit_in;
    else
      skip_next <= 1'b0;
  end

  // one-instruction arming of power-off and watchdog stop
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pwr_off_armed_r <= 1'b0;
      wd_disable_armed_r <= 1'b0;
      ram_backup <= 1'b0;
      wdt_stop <= 1'b0;
      watchdog_flag_one_r <= 1'b0;
      sys_reset_req <= 1'b0;
    end
    else
    begin
      ram_backup <= first_ok && op == `ASID_OP_POWER_OFF && pwr_off_armed_r;
      sys_reset_req <= first_ok && op == `ASID_OP_SOFTWARE_RESET;
      if (first_ok)
      begin
        pwr_off_armed_r <= op == `ASID_OP_POWER_OFF_ENABLE;
        wd_disable_armed_r <= op == `ASID_OP_WATCHDOG_DISABLE;
        if (op == `ASID_OP_WATCHDOG_RESTART && wd_disable_armed_r)
          wdt_stop <= 1'b1;
      end
      else if (second_ok)
      begin
        pwr_off_armed_r <= 1'b0;
        wd_disable_armed_r <= 1'b0;
      end
      if (watchdog_flag_one_set)
        watchdog_flag_one_r <= 1'b1;
      else if (first_ok && op == `ASID_OP_WATCHDOG_RESTART)
        watchdog_flag_one_r <= 1'b0;
    end
  end

  // sticky event status, write one to clear; a new event wins over the clear
  assign ev[`ASID_ST_DONE] = conv_complete;
  assign ev[`ASID_ST_WDF] = watchdog_flag_one_set;
  assign ev[`ASID_ST_BACKUP] = first_ok && op == `ASID_OP_POWER_OFF && pwr_off_armed_r;
  assign ev[`ASID_ST_SWRST] = first_ok && op == `ASID_OP_SOFTWARE_RESET;
  assign w1c = (wr_fire && w_lane_q && wsel == {1'b1, `ASID_OFF_STATUS}) ?
               w_data_q[`ASID_ST_W-1:0] : '0;

  genvar g;
  generate
    for (g = 0; g < `ASID_ST_W; g++)
    begin : g_status
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
        if (sys_rst)
          status_r[g] <= 1'b0;
        else
          status_r[g] <= ev[g] | (status_r[g] & ~w1c[g]);
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mask_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_fire && w_lane_q && wsel == {1'b1, `ASID_OFF_MASK})
        mask_r <= w_data_q[`ASID_ST_W-1:0];
      irq <= |(status_r & mask_r);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_rdy_r <= 1'b1;
      w_rdy_r <= 1'b1;
      b_vld_r <= 1'b0;
      b_resp_r <= `ASID_RESP_OKAY;
      aw_addr_q <= 32'h0;
      w_data_q <= 32'h0;
      w_lane_q <= 1'b0;
    end
    else
    begin
      if (axi_m2s.awvalid && aw_rdy_r)
      begin
        aw_addr_q <= axi_m2s.awaddr;
        aw_rdy_r <= 1'b0;
      end
      if (axi_m2s.wvalid && w_rdy_r)
      begin
        w_data_q <= axi_m2s.wdata;
        w_lane_q <= axi_m2s.wstrb[0];
        w_rdy_r <= 1'b0;
      end
      if (wr_fire)
      begin
        b_vld_r <= 1'b1;
        b_resp_r <= wsel[3] ? `ASID_RESP_OKAY : `ASID_RESP_SLVERR;
      end
      if (b_vld_r && axi_m2s.bready)
      begin
        b_vld_r <= 1'b0;
        aw_rdy_r <= 1'b1;
        w_rdy_r <= 1'b1;
      end
    end
  end

  // bus read path; data is captured at the address handshake
  logic ar_rdy_r;
  logic r_vld_r;
  logic [31:0] r_data_r;
  logic [1:0] r_resp_r;
  logic [3:0] rsel;
  logic [31:0] rd_mux;

  assign rsel = reg_sel(axi_m2s.araddr);

  always_comb
  begin
    rd_mux = 32'h0;
    case (rsel[2:0])
      `ASID_OFF_STATUS: rd_mux = {28'h0, status_r};
      `ASID_OFF_MASK: rd_mux = {28'h0, mask_r};
      `ASID_OFF_CTRL1: rd_mux = {28'h0, ctrl_r[0]};
      `ASID_OFF_CTRL2: rd_mux = {28'h0, ctrl_r[1]};
      `ASID_OFF_CTRL3: rd_mux = {28'h0, ctrl_r[2]};
      `ASID_OFF_CMPREF: rd_mux = {24'h0, cmp_ref};
      `ASID_OFF_STATE: rd_mux = {26'h0, wd_disable_armed_r, pwr_off_armed_r, mode, wdt_stop,
                                 watchdog_flag_one_r, conv_done_flag_r};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ar_rdy_r <= 1'b1;
      r_vld_r <= 1'b0;
      r_data_r <= 32'h0;
      r_resp_r <= `ASID_RESP_OKAY;
    end
    else if (axi_m2s.arvalid && ar_rdy_r)
    begin
      ar_rdy_r <= 1'b0;
      r_vld_r <= 1'b1;
      r_data_r <= rsel[3] ? rd_mux : 32'h0;
      r_resp_r <= rsel[3] ? `ASID_RESP_OKAY : `ASID_RESP_SLVERR;
    end
    else if (r_vld_r && axi_m2s.rready)
    begin
      r_vld_r <= 1'b0;
      ar_rdy_r <= 1'b1;
    end
  end

  assign axi_s2m = {aw_rdy_r, w_rdy_r, b_vld_r, b_resp_r, ar_rdy_r, r_vld_r, r_data_r, r_resp_r};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_pair_conv: assert property (first_ok && op == `ASID_OP_READ_RESULT_PAIR && !mode |=>
    acc_we && regb_we && regb_out == $past(adc_result[9:6]) && acc_out == $past(adc_result[5:2]))
    else $error("result pair read wrong in conversion mode");
  a_pair_comp: assert property (first_ok && op == `ASID_OP_READ_RESULT_PAIR && mode |=>
    regb_out == $past(adc_result[7:4]) && acc_out == $past(adc_result[3:0]))
    else $error("result pair read wrong in comparator mode");
  a_low_bits: assert property (first_ok && op == `ASID_OP_READ_RESULT_LOW_BITS |=>
    acc_we && acc_out == {$past(adc_result[1:0]), 2'b00})
    else $error("low bits read wrong");
  a_ref_load: assert property (first_ok && op == `ASID_OP_LOAD_COMPARATOR_REF && mode |=>
    cmp_ref == {$past(regb_in), $past(acc_in)})
    else $error("comparator reference not loaded");
  a_start_clear: assert property (first_ok && op == `ASID_OP_START_CONVERSION && !conv_complete
    |=> !conv_done_flag && conv_start == !$past(mode) && cmp_start == $past(mode))
    else $error("start did not clear flag or pick mode");
  a_done_skip: assert property (first_ok && op == `ASID_OP_TEST_CONV_DONE
    && !converter_irq_enable_bit && !conv_complete |=> skip_next == $past(conv_done_flag_r)
    && !conv_done_flag)
    else $error("done test skip wrong");
  a_done_nop: assert property (first_ok && op == `ASID_OP_TEST_CONV_DONE
    && converter_irq_enable_bit |=> !skip_next && conv_done_flag >= $past(conv_done_flag_r))
    else $error("done test acted while irq enabled");
  a_ctrl_write: assert property (first_ok && op == `ASID_OP_WR_CTRL2 |=>
    ctrl_r[1] == $past(acc_in))
    else $error("control register write wrong");
  a_ctrl_read: assert property (first_ok && op == `ASID_OP_RD_CTRL2 |=>
    acc_we && acc_out == $past(ctrl_r[1]))
    else $error("control register read wrong");
  a_nop_quiet: assert property (first_ok && op == `ASID_OP_NO_OPERATION |=>
    !skip_next && !acc_we && !regb_we && $stable(cmp_ref) && !ram_backup)
    else $error("no-operation changed state");
  a_backup_arm: assert property (first_ok && op == `ASID_OP_POWER_OFF |=>
    ram_backup == $past(pwr_off_armed_r))
    else $error("power-off arming wrong");
  a_power_skip: assert property (first_ok && op == `ASID_OP_TEST_POWER_DOWN_FLAG |=>
    skip_next == $past(power_flag_in))
    else $error("power flag skip wrong");
  a_wd_skip: assert property (first_ok && op == `ASID_OP_WATCHDOG_RESTART
    && !watchdog_flag_one_set |=> skip_next == $past(watchdog_flag_one_r)
    && !watchdog_flag_one_r)
    else $error("watchdog restart skip wrong");
  a_wdt_stop: assert property (first_ok && op == `ASID_OP_WATCHDOG_DISABLE ##1
    first_ok && op == `ASID_OP_WATCHDOG_RESTART |=> wdt_stop)
    else $error("watchdog not stopped");
  a_two_word: assert property (first_ok && two_word ##1 instr_valid |=> operand_valid)
    else $error("operand word not consumed");
endmodule

// ==== logic/asid_pkg.sv ====
// types shared by the converter/system instruction decoder
package asid_pkg;

  typedef enum logic {
    ASID_ST_FIRST = 1'b0,
    ASID_ST_SECOND = 1'b1
  } asid_state_t;

  typedef enum logic [1:0] {
    ASID_W2_LONG = 2'b00,
    ASID_W2_INDEX = 2'b01,
    ASID_W2_EQ = 2'b10,
    ASID_W2_PORT = 2'b11
  } asid_w2_t;

  typedef struct packed {
    logic call;
    asid_w2_t kind;
    logic [6:0] page;
    logic [6:0] addr;
  } asid_operand_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } asid_axi_m2s_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } asid_axi_s2m_t;

endpackage
